/* File: verilog/adc_ctrl.v */
// Converter control: calibration, modes, overrun, injection and APB registers.
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "adc_defines.vh"

// Overview of operation
// - After reset a self-calibration runs its full length with busy set.
// - No conversion starts during calibration; software polls busy first.
// - Each conversion yields a 10-bit result from one of 16+8 channels.
// - One control bit picks the first or second port channel group.
// - Sample time and conversion time are software programmable.
// - A result completing over an unread one raises an overrun interrupt.
// - Optionally the next conversion waits until the old result is read.
// - Single channel single mode converts once, stores, then stops.
// - Single channel continuous mode converts the channel over and over.
// - Scan single mode converts each selected channel once, storing each.
// - Scan continuous mode cycles the selected channels repeatedly.
// - Every stored result can trigger a transfer by interrupt or event.
// - Wait-for-read in continuous mode buffers the result and pauses.
// - Injection converts one channel between continuous ones, own register.
// - After an injection the continuous mode resumes unchanged.
// - Unused analog inputs stay usable as digital inputs.
module adc_ctrl #(
	parameter CAL_CYCLES = `ADC_CAL_CYCLES,
	parameter RES        = 10,
	parameter NCH        = 24
) (
	input  wire            clk_i,
	input  wire            rst_i,
	input  wire            psel_i,
	input  wire            penable_i,
	input  wire            pwrite_i,
	input  wire [7:0]      paddr_i,
	input  wire [31:0]     pwdata_i,
	output reg  [31:0]     prdata_o,
	output reg             pready_o,
	output reg             pslverr_o,
	input  wire            cmp_i,
	output wire            sample_o,
	output wire [RES-1:0]  trial_o,
	output reg  [4:0]      mux_sel_o,
	output reg  [NCH-1:0]  dig_en_o,
	output reg             xfer_req_o,
	output reg             irq_o
);

	////////////////////////////////////////////////////////////////////////
	// Register state.
	reg  [3:0]     ch_r;
	reg  [1:0]     mode_r;
	reg            run_r;
	reg            wfr_r;
	reg            port_r;
	reg            ovr_susp_r;
	reg  [3:0]     inj_ch_r;
	reg  [15:0]    timing_r;
	reg  [`ADC_ST_W-1:0] status_r;
	reg  [`ADC_ST_W-1:0] mask_r;
	reg  [RES-1:0] result_r;
	reg  [3:0]     result_ch_r;
	reg  [RES-1:0] inj_res_r;
	reg  [3:0]     inj_res_ch_r;
	reg  [RES-1:0] buf_r;
	reg  [3:0]     buf_ch_r;
	reg            hold_r;
	reg            pend_r;
	reg            inj_pend_r;
	reg            inj_act_r;
	reg  [3:0]     cur_ch_r;
	reg  [15:0]    cal_cnt_r;
	reg            cal_r;
	reg            start_r;
	reg            cmp_s1_r;
	reg            cmp_s2_r;
	wire           sar_busy;
	wire           sar_done;
	wire [RES-1:0] sar_res;

	////////////////////////////////////////////////////////////////////////
	// Maps a channel number inside the chosen group onto the analog mux.
	function [4:0] mux_of;
		input       port;
		input [3:0] ch;
		begin
			mux_of = port ? {2'b10, ch[2:0]} : {1'b0, ch};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// APB decode; the access phase always completes in its first cycle.
	wire acc    = psel_i & penable_i & pready_o;
	wire wr_acc = acc & pwrite_i;
	wire rd_acc = acc & ~pwrite_i;
	wire hit_ctrl = (paddr_i == `ADC_OFS_CTRL);
	wire hit_res  = (paddr_i == `ADC_OFS_RESULT);
	wire hit_stat = (paddr_i == `ADC_OFS_STATUS);
	wire mapped   = hit_ctrl | hit_res | hit_stat | (paddr_i == `ADC_OFS_INJRES)
	              | (paddr_i == `ADC_OFS_MASK) | (paddr_i == `ADC_OFS_TIMING);
	wire wr_ctrl  = wr_acc & hit_ctrl;
	wire rd_res   = rd_acc & hit_res;
	wire busy     = cal_r | run_r | sar_busy;
	wire cont     = mode_r[`ADC_MODE_CONT];
	wire scan     = mode_r[`ADC_MODE_SCAN];

	// Launch conditions. The cycles of a launch and of a finish are skipped, so that
	// the mux, the next channel and the run bit have settled first.
	// An injection ignores the read hold, since its result has its own register.
	wire idle     = ~cal_r & ~sar_busy & ~start_r & ~sar_done;
	wire can_go   = idle & ~hold_r;
	wire go_inj   = idle & inj_pend_r & run_r & cont;
	wire go_norm  = can_go & ~inj_pend_r & run_r
	              & ~(ovr_susp_r & pend_r);
	wire done_n   = sar_done & ~inj_act_r;
	wire done_i   = sar_done & inj_act_r;
	wire to_buf   = done_n & cont & wfr_r & pend_r & ~rd_res;
	wire store    = done_n & ~to_buf;
	wire ovr_evt  = store & pend_r & ~rd_res;

	////////////////////////////////////////////////////////////////////////
	// Comparator input from the analog side passes two flip-flops.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cmp_s1_r <= 1'b0;
			cmp_s2_r <= 1'b0;
		end
		else
		begin
			cmp_s1_r <= cmp_i;
			cmp_s2_r <= cmp_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Self-calibration window counted from reset release.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cal_r     <= 1'b1;
			cal_cnt_r <= 16'h0000;
		end
		else if (cal_r)
		begin
			if (cal_cnt_r == CAL_CYCLES[15:0] - 16'h0001)
				cal_r <= 1'b0;
			else
				cal_cnt_r <= cal_cnt_r + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Software configuration registers.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			ch_r       <= 4'h0;
			mode_r     <= 2'b00;
			wfr_r      <= 1'b0;
			port_r     <= 1'b0;
			ovr_susp_r <= 1'b0;
			inj_ch_r   <= 4'h0;
			timing_r   <= `ADC_TIMING_RST;
			mask_r     <= `ADC_MASK_RST;
		end
		else if (wr_acc)
		begin
			if (hit_ctrl)
			begin
				ch_r       <= pwdata_i[`ADC_CTRL_CH_LSB +: 4];
				mode_r     <= pwdata_i[`ADC_CTRL_MODE_LSB +: 2];
				wfr_r      <= pwdata_i[`ADC_CTRL_WFR];
				port_r     <= pwdata_i[`ADC_CTRL_PORT];
				ovr_susp_r <= pwdata_i[`ADC_CTRL_OVRSUSP];
				inj_ch_r   <= pwdata_i[`ADC_CTRL_INJCH +: 4];
			end
			if (paddr_i == `ADC_OFS_TIMING)
				timing_r <= pwdata_i[15:0];
			if (paddr_i == `ADC_OFS_MASK)
				mask_r <= pwdata_i[`ADC_ST_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Run control, channel sequencing and injection tracking.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			run_r      <= 1'b0;
			cur_ch_r   <= 4'h0;
			inj_pend_r <= 1'b0;
			inj_act_r  <= 1'b0;
		end
		else
		begin
			if (wr_ctrl & ~cal_r)
			begin
				run_r    <= pwdata_i[`ADC_CTRL_START];
				cur_ch_r <= pwdata_i[`ADC_CTRL_CH_LSB +: 4];
			end
			else if (done_n)
			begin
				if (scan & (cur_ch_r != 4'h0))
					cur_ch_r <= cur_ch_r - 4'h1;
				else if (cont)
					cur_ch_r <= ch_r;
				else
					run_r <= 1'b0;
			end
			if (go_inj)
			begin
				inj_pend_r <= 1'b0;
				inj_act_r  <= 1'b1;
			end
			else if (wr_ctrl & pwdata_i[`ADC_CTRL_INJ] & run_r & cont)
				inj_pend_r <= 1'b1;
			if (done_i)
				inj_act_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result, hold buffer and unread tracking; a new result beats a read.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			result_r     <= {RES{1'b0}};
			result_ch_r  <= 4'h0;
			inj_res_r    <= {RES{1'b0}};
			inj_res_ch_r <= 4'h0;
			buf_r        <= {RES{1'b0}};
			buf_ch_r     <= 4'h0;
			hold_r       <= 1'b0;
			pend_r       <= 1'b0;
		end
		else
		begin
			if (to_buf)
			begin
				buf_r    <= sar_res;
				buf_ch_r <= cur_ch_r;
				hold_r   <= 1'b1;
			end
			if (store)
			begin
				result_r    <= sar_res;
				result_ch_r <= cur_ch_r;
				pend_r      <= 1'b1;
			end
			else if (rd_res & hold_r)
			begin
				result_r    <= buf_r;
				result_ch_r <= buf_ch_r;
				hold_r      <= 1'b0;
				pend_r      <= 1'b1;
			end
			else if (rd_res & ~to_buf)
				pend_r <= 1'b0;
			if (done_i)
			begin
				inj_res_r    <= sar_res;
				inj_res_ch_r <= inj_ch_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky event bits: set wins over a write-one clear.
	wire [`ADC_ST_W-1:0] st_set = {cal_r & (cal_cnt_r == CAL_CYCLES[15:0] - 16'h0001),
	                               done_i, ovr_evt, store | (rd_res & hold_r)};
	wire [`ADC_ST_W-1:0] st_clr = (wr_acc & hit_stat) ? pwdata_i[`ADC_ST_W-1:0]
	                                                   : {`ADC_ST_W{1'b0}};
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			status_r   <= {`ADC_ST_W{1'b0}};
			irq_o      <= 1'b0;
			xfer_req_o <= 1'b0;
		end
		else
		begin
			status_r   <= (status_r & ~st_clr) | st_set;
			irq_o      <= |(((status_r & ~st_clr) | st_set) & mask_r);
			xfer_req_o <= st_set[`ADC_ST_DONE];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mux select follows the launch; digital buffers stay on for unused pins.
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi = gi + 1)
		begin : g_dig
			wire [31:0] idx_w = gi;
			wire [4:0] idx = idx_w[4:0];
			wire in_grp = port_r ? (idx[4:3] == 2'b10) : (idx[4] == 1'b0);
			wire [3:0] loc = port_r ? {1'b0, idx[2:0]} : idx[3:0];
			wire used = in_grp & ((scan ? (loc <= ch_r) : (loc == ch_r))
			          | (inj_pend_r | inj_act_r) & (loc == inj_ch_r));
			always @(posedge clk_i or posedge rst_i)
			begin
				if (rst_i)
					dig_en_o[gi] <= 1'b1;
				else
					dig_en_o[gi] <= ~(used & busy);
			end
		end
	endgenerate

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			mux_sel_o <= 5'h00;
		else if (go_inj)
			mux_sel_o <= mux_of(port_r, inj_ch_r);
		else if (go_norm)
			mux_sel_o <= mux_of(port_r, cur_ch_r);
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion engine, started one cycle after the mux has moved.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			start_r <= 1'b0;
		else
			start_r <= (go_inj | go_norm) & ~start_r;
	end

	adc_sar #(
		.RES          (RES)
	) u_sar (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.start_i      (start_r),
		.sample_len_i (timing_r[7:0]),
		.bit_len_i    (timing_r[15:8]),
		.cmp_i        (cmp_s2_r),
		.sample_o     (sample_o),
		.trial_o      (trial_o),
		.busy_o       (sar_busy),
		.done_o       (sar_done),
		.result_o     (sar_res)
	);

	////////////////////////////////////////////////////////////////////////
	// Read data captured in the setup cycle; answer in the first access cycle.
	reg [31:0] rdata;
	always @*
	begin
		rdata = 32'h0000_0000;
		case (paddr_i)
			`ADC_OFS_CTRL:
			begin
				rdata[`ADC_CTRL_CH_LSB +: 4]   = ch_r;
				rdata[`ADC_CTRL_MODE_LSB +: 2] = mode_r;
				rdata[`ADC_CTRL_START]         = run_r;
				rdata[`ADC_CTRL_BUSY]          = busy;
				rdata[`ADC_CTRL_WFR]           = wfr_r;
				rdata[`ADC_CTRL_INJ]           = inj_pend_r | inj_act_r;
				rdata[`ADC_CTRL_PORT]          = port_r;
				rdata[`ADC_CTRL_OVRSUSP]       = ovr_susp_r;
				rdata[`ADC_CTRL_INJCH +: 4]    = inj_ch_r;
			end
			`ADC_OFS_RESULT:
			begin
				rdata[RES-1:0]                 = result_r;
				rdata[`ADC_RES_CH_LSB +: 4]    = result_ch_r;
			end
			`ADC_OFS_INJRES:
			begin
				rdata[RES-1:0]                 = inj_res_r;
				rdata[`ADC_RES_CH_LSB +: 4]    = inj_res_ch_r;
			end
			`ADC_OFS_STATUS: rdata[`ADC_ST_W-1:0] = status_r;
			`ADC_OFS_MASK:   rdata[`ADC_ST_W-1:0] = mask_r;
			`ADC_OFS_TIMING: rdata[15:0]          = timing_r;
			default:         rdata = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o  <= psel_i & ~penable_i;
			pslverr_o <= psel_i & ~penable_i & ~mapped;
			if (psel_i & ~penable_i & ~pwrite_i)
				prdata_o <= rdata;
		end
	end

endmodule // adc_ctrl

/* File: verilog/adc_defines.vh */
// Register map, field positions, reset values and timing for the converter control.
`ifndef ADC_DEFINES_VH
`define ADC_DEFINES_VH

// Register byte offsets.
`define ADC_OFS_CTRL    8'h00
`define ADC_OFS_RESULT  8'h04
`define ADC_OFS_INJRES  8'h08
`define ADC_OFS_STATUS  8'h0c
`define ADC_OFS_MASK    8'h10
`define ADC_OFS_TIMING  8'h14

// Control register fields.
`define ADC_CTRL_CH_LSB   0
`define ADC_CTRL_MODE_LSB 4
`define ADC_CTRL_START    6
`define ADC_CTRL_BUSY     7
`define ADC_CTRL_WFR      8
`define ADC_CTRL_INJ      9
`define ADC_CTRL_PORT     10
`define ADC_CTRL_OVRSUSP  11
`define ADC_CTRL_INJCH    12

// Result registers: value field and channel field.
`define ADC_RES_CH_LSB    12

// Status and mask bits.
`define ADC_ST_DONE       0
`define ADC_ST_OVR        1
`define ADC_ST_INJ        2
`define ADC_ST_CAL        3
`define ADC_ST_W          4

// Mode encoding bits.
`define ADC_MODE_CONT     0
`define ADC_MODE_SCAN     1

// Reset values.
`define ADC_TIMING_RST    16'h0303
`define ADC_MASK_RST      4'h0

// Calibration length in CPU clock cycles.
`define ADC_CAL_CYCLES    40630

`endif

/* File: verilog/adc_sar.v */
// Successive-approximation engine: sample phase then one trial per result bit.
`timescale 1ns/1ps
module adc_sar #(
	parameter RES = 10
) (
	input  wire           clk_i,
	input  wire           rst_i,
	input  wire           start_i,
	input  wire [7:0]     sample_len_i,
	input  wire [7:0]     bit_len_i,
	input  wire           cmp_i,
	output reg            sample_o,
	output reg  [RES-1:0] trial_o,
	output reg            busy_o,
	output reg            done_o,
	output reg  [RES-1:0] result_o
);

	reg [7:0] cnt_r;
	reg [3:0] bit_r;

	////////////////////////////////////////////////////////////////////////
	// Sample for sample_len+1 cycles, then settle each trial bit_len+1 cycles.
	always @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sample_o <= 1'b0;
			trial_o  <= {RES{1'b0}};
			busy_o   <= 1'b0;
			done_o   <= 1'b0;
			result_o <= {RES{1'b0}};
			cnt_r    <= 8'h00;
			bit_r    <= 4'h0;
		end
		else
		begin
			done_o <= 1'b0;
			if (!busy_o)
			begin
				if (start_i)
				begin
					busy_o   <= 1'b1;
					sample_o <= 1'b1;
					cnt_r    <= sample_len_i;
				end
			end
			else if (cnt_r != 8'h00)
				cnt_r <= cnt_r - 8'h01;
			else if (sample_o)
			begin
				// Hold the sample and put up the most significant trial.
				sample_o <= 1'b0;
				bit_r    <= RES[3:0] - 4'h1;
				trial_o  <= {1'b1, {(RES-1){1'b0}}};
				cnt_r    <= bit_len_i;
			end
			else
			begin
				// Keep the trial bit when the input is above the trial level.
				if (bit_r == 4'h0)
				begin
					result_o <= cmp_i ? trial_o : (trial_o & ~{{(RES-1){1'b0}}, 1'b1});
					busy_o   <= 1'b0;
					done_o   <= 1'b1;
					trial_o  <= {RES{1'b0}};
				end
				else
				begin
					trial_o       <= (cmp_i ? trial_o : (trial_o & ~({{(RES-1){1'b0}}, 1'b1}
					                 << bit_r))) | ({{(RES-1){1'b0}}, 1'b1} << (bit_r - 4'h1));
					bit_r         <= bit_r - 4'h1;
					cnt_r         <= bit_len_i;
				end
			end
		end
	end

endmodule // adc_sar

/* File: testbench/adc_ctrl_sva.sv */
// Port assertions for the converter control.
`timescale 1ns/1ps
module adc_ctrl_sva #(
	parameter CAL_CYCLES = 40630
) (
	input wire        clk_i,
	input wire        rst_i,
	input wire        psel_i,
	input wire        penable_i,
	input wire        pwrite_i,
	input wire [7:0]  paddr_i,
	input wire [31:0] prdata_o,
	input wire        pready_o,
	input wire        pslverr_o,
	input wire        sample_o,
	input wire [4:0]  mux_sel_o,
	input wire        xfer_req_o,
	input wire        irq_o
);
	integer cal_cnt_r;
	wire    mapped;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Counts cycles since reset release, saturating at the calibration length.
	always @(posedge clk_i or posedge rst_i)
		if (rst_i)
			cal_cnt_r <= 0;
		else if (cal_cnt_r < CAL_CYCLES)
			cal_cnt_r <= cal_cnt_r + 1;
	// Aligned word offsets up to the timing register are decoded.
	assign mapped = (paddr_i <= 8'h14) && (paddr_i[1:0] == 2'b00);
	////////////////////////////////////////////////////////////////////////////
	a_no_sample_cal: assert property (cal_cnt_r < CAL_CYCLES |-> !sample_o)
		else $error("sampling during calibration");
	a_mux_in_range: assert property (mux_sel_o < 5'h18)
		else $error("mux select beyond last channel");
	a_xfer_single: assert property (xfer_req_o |=> !xfer_req_o)
		else $error("transfer request longer than one cycle");
	a_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready in first access cycle");
	a_ready_once: assert property (pready_o |=> !pready_o)
		else $error("ready held over one cycle");
	a_idle_ready: assert property (!psel_i |=> !pready_o)
		else $error("ready without a transfer");
	a_unmapped_err: assert property (pready_o && !mapped |-> pslverr_o)
		else $error("unmapped access not refused");
	a_read_hold: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
		else $error("read data moved without a read");
	c_xfer: cover property (xfer_req_o);
	c_err: cover property (pslverr_o);
	c_irq: cover property (irq_o);
endmodule // adc_ctrl_sva

/* File: testbench/adc_ain_model.sv */
// Analog multiplexer, sample-and-hold and comparator in front of the converter.
`timescale 1ns/1ps
module adc_ain_model (
	input  wire       clk_i,
	input  wire       sample_i,
	input  wire [4:0] mux_sel_i,
	input  wire [9:0] trial_i,
	output wire       cmp_o
);
	reg [9:0] held_r = 10'h000;
	// The hold capacitor follows the selected input while sampling.
	always @(posedge clk_i)
		if (sample_i)
			held_r <= {mux_sel_i, 5'h0b};
	// Level sits half a code above its value, so no trial ever ties with it.
	assign cmp_o = {held_r, 1'b1} > {trial_i, 1'b0};
endmodule // adc_ain_model

/* File: testbench/adc_sequencer_control_bench.sv */
// Self-checking bench for the converter control with its analog front model.
`timescale 1ns/1ps
`include "adc_defines.vh"
module adc_sequencer_control_bench;
	localparam CAL = 20;
	reg         clk_i = 1'b0;
	reg         rst_i = 1'b1;
	reg         psel_i = 1'b0;
	reg         penable_i = 1'b0;
	reg         pwrite_i = 1'b0;
	reg  [7:0]  paddr_i = 8'h00;
	reg  [31:0] pwdata_i = 32'h0;
	wire [31:0] prdata_o;
	wire        pready_o, pslverr_o, cmp_i, sample_o, xfer_req_o, irq_o;
	wire [9:0]  trial_o;
	wire [4:0]  mux_sel_o;
	wire [23:0] dig_en_o;
	integer     err_count = 0, checks = 0, cyc = 0, xfers = 0, t0, x0, i;
	reg  [31:0] rd;
	reg         err;
	always #12.5 clk_i = ~clk_i;
	// Cycle and transfer-request counters.
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (xfer_req_o === 1'b1)
			xfers <= xfers + 1;
	end
	adc_ctrl #(.CAL_CYCLES(CAL)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cmp_i(cmp_i),
		.sample_o(sample_o), .trial_o(trial_o), .mux_sel_o(mux_sel_o), .dig_en_o(dig_en_o),
		.xfer_req_o(xfer_req_o), .irq_o(irq_o));
	adc_ain_model u_model (.clk_i(clk_i), .sample_i(sample_o), .mux_sel_i(mux_sel_o),
		.trial_i(trial_o), .cmp_o(cmp_i));
	////////////////////////////////////////////////////////////////////////////
	// Expected result word: channel field and the model's level for a mux input.
	function [31:0] res(input [3:0] ch, input [4:0] sel);
		res = {16'h0, ch, 2'b00, sel, 5'h0b};
	endfunction
	// Counts a comparison and reports a mismatch.
	task chk(input [31:0] seen, input [31:0] exp, input string what);
	begin
		checks = checks + 1;
		if (seen !== exp)
		begin
			err_count = err_count + 1;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	// One bus transfer; the request stands until ready is sampled high.
	task apb(input wr, input [7:0] a, input [31:0] d);
	begin
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		@(posedge clk_i);
		while (pready_o !== 1'b1)
			@(posedge clk_i);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	end
	endtask
	// Reads a register until the masked bits match, with a bounded count.
	task poll(input [7:0] a, input [31:0] m, input [31:0] want);
		integer n;
	begin
		n = 0;
		apb(1'b0, a, 32'h0);
		while ((rd & m) !== want && n < 400)
		begin
			n = n + 1;
			apb(1'b0, a, 32'h0);
		end
	end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task final_report;
	begin
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	// Cuts a hang short.
	initial
	begin
		#(25 * 20000);
		err_count = err_count + 1;
		final_report;
	end
	////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t0 = cyc;
		apb(1'b0, `ADC_OFS_CTRL, 32'h0);
		chk(rd[7], 32'h1, "busy");
		apb(1'b1, `ADC_OFS_CTRL, 32'h0000_0040);
		poll(`ADC_OFS_CTRL, 32'h80, 32'h0);
		chk((cyc - t0 >= CAL) && (cyc - t0 <= CAL + 12), 32'h1, "cal length");
		chk(rd[6], 32'h0, "start during cal");
		apb(1'b0, `ADC_OFS_STATUS, 32'h0);
		chk(rd[3], 32'h1, "cal done");
		apb(1'b0, `ADC_OFS_TIMING, 32'h0);
		chk(rd, 32'h0000_0303, "timing reset");
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		$display("calibration test done");
		apb(1'b1, `ADC_OFS_TIMING, 32'h0000_0404);
		apb(1'b0, `ADC_OFS_TIMING, 32'h0);
		chk(rd, 32'h0000_0404, "timing");
		x0 = xfers;
		apb(1'b1, `ADC_OFS_CTRL, 32'h0000_0045);
		poll(`ADC_OFS_CTRL, 32'h40, 32'h0);
		apb(1'b0, `ADC_OFS_RESULT, 32'h0);
		chk(rd, res(5, 5), "single");
		chk(xfers - x0, 32'h1, "single xfers");
		apb(1'b1, `ADC_OFS_CTRL, 32'h0000_0443);
		poll(`ADC_OFS_CTRL, 32'h40, 32'h0);
		apb(1'b0, `ADC_OFS_RESULT, 32'h0);
		chk(rd, res(3, 19), "second group");
		$display("single test done");
		apb(1'b1, `ADC_OFS_STATUS, 32'h0000_000f);
		x0 = xfers;
		apb(1'b1, `ADC_OFS_CTRL, 32'h0000_0062);
		poll(`ADC_OFS_CTRL, 32'h40, 32'h0);
		chk(xfers - x0, 32'h3, "scan xfers");
		apb(1'b0, `ADC_OFS_RESULT, 32'h0);
		chk(rd, res(0, 0), "scan last");
		apb(1'b0, `ADC_OFS_STATUS, 32'h0);
		chk(rd[1], 32'h1, "overrun");
		chk(irq_o, 32'h0, "irq masked");
		apb(1'b1, `ADC_OFS_MASK, 32'h0000_0002);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 32'h1, "irq");
		apb(1'b1, `ADC_OFS_STATUS, 32'h0000_0002);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 32'h0, "irq cleared");
		$display("scan test done");
		apb(1'b1, `ADC_OFS_CTRL, 32'h0000_0154);
		repeat (20) @(posedge clk_i);
		chk(dig_en_o[5:4], 32'h2, "digital inputs");
		for (i = 0; i < 3; i = i + 1)
		begin
			repeat (150) @(posedge clk_i);
			apb(1'b0, `ADC_OFS_RESULT, 32'h0);
			chk(rd, res(4, 4), "continuous");
		end
		apb(1'b0, `ADC_OFS_STATUS, 32'h0);
		chk(rd[1], 32'h0, "wait for read");
		apb(1'b1, `ADC_OFS_CTRL, 32'h0000_7354);
		poll(`ADC_OFS_STATUS, 32'h4, 32'h4);
		apb(1'b0, `ADC_OFS_INJRES, 32'h0);
		chk(rd, res(7, 7), "injection");
		apb(1'b0, `ADC_OFS_CTRL, 32'h0);
		chk({rd[6:4], rd[3:0]}, 32'h54, "mode kept");
		apb(1'b1, `ADC_OFS_CTRL, 32'h0);
		repeat (150) @(posedge clk_i);
		apb(1'b0, `ADC_OFS_RESULT, 32'h0);
		apb(1'b0, `ADC_OFS_RESULT, 32'h0);
		apb(1'b1, `ADC_OFS_STATUS, 32'h0000_000f);
		$display("continuous test done");
		apb(1'b1, `ADC_OFS_CTRL, 32'h0000_0871);
		for (i = 0; i < 3; i = i + 1)
		begin
			repeat (200) @(posedge clk_i);
			apb(1'b0, `ADC_OFS_RESULT, 32'h0);
			chk(rd, (i == 1) ? res(0, 0) : res(1, 1), "scan continuous");
		end
		apb(1'b0, `ADC_OFS_STATUS, 32'h0);
		chk(rd[1], 32'h0, "suspend");
		apb(1'b1, `ADC_OFS_CTRL, 32'h0);
		repeat (150) @(posedge clk_i);
		chk(dig_en_o, 32'h00ff_ffff, "digital idle");
		$display("suspend test done");
		final_report;
	end
endmodule // adc_sequencer_control_bench

bind adc_ctrl adc_ctrl_sva #(.CAL_CYCLES(CAL_CYCLES)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_o(sample_o),
	.mux_sel_o(mux_sel_o), .xfer_req_o(xfer_req_o), .irq_o(irq_o));
